// ==== logic/iqdw_consts.svh ====
// Register offsets, field positions, pin numbers and reset values
`ifndef IQDW_CONSTS_SVH
`define IQDW_CONSTS_SVH

// Register byte offsets within the I/O memory window
`define IQDW_OFF_IRQ 8'h40
`define IQDW_OFF_DIGITAL_LINE_DATA 8'h44
`define IQDW_OFF_DIO_CTRL 8'h48
`define IQDW_OFF_WDG 8'h4C

// Interrupt register layout
`define IQDW_IRQ_EN_LSB 0
`define IQDW_IRQ_EN_MSB 8
`define IQDW_IRQ_FLAG_LSB 16
`define IQDW_IRQ_FLAG_MSB 24
`define IQDW_IRQ_WDG_BIT 31
`define IQDW_IRQ_SRC_COUNT 9

// Source positions inside the nine-bit enable and flag vectors
`define IQDW_SRC_TRIG 0
`define IQDW_SRC_START 1
`define IQDW_SRC_DMA_DONE_FLAG 2
`define IQDW_SRC_DTO 3
`define IQDW_SRC_FAF 4
`define IQDW_SRC_FOF 5
`define IQDW_SRC_DAC_LOAD_FLAG 6
`define IQDW_SRC_EXT0 7
`define IQDW_SRC_EXT1 8

// Digital line control layout
`define IQDW_DIO_GRP0_BIT 0
`define IQDW_DIO_GRP1_BIT 1
`define IQDW_DIO_SEC_LSB 16
`define IQDW_DIO_SEC_MSB 23
`define IQDW_DIO_WIDTH 16
`define IQDW_DIO_GRP_WIDTH 8

// Secondary function pins, in edge-detector lane order
`define IQDW_PIN_TRIG 15
`define IQDW_PIN_START 14
`define IQDW_PIN_EXT 13
`define IQDW_PIN_DAC_LOAD_FLAG 12
`define IQDW_SEC_COUNT 4

// Reset values
`define IQDW_RST_IRQ_EN 9'h000
`define IQDW_RST_IRQ_FLAG 9'h000
`define IQDW_RST_DIGITAL_LINE_DATA 16'h0000
`define IQDW_RST_DIO_GRP 2'h0
`define IQDW_RST_DIO_SEC 8'h00
`define IQDW_RST_WDG_TIMEOUT 32'h0000_0000
`define IQDW_RST_WORD 32'h0000_0000

`endif

// ==== logic/iqdw_ctrl.sv ====
// Interrupt status, digital line port and watchdog control core
// Operation
// - Interrupt register reads fired flags in upper bits, enables in low bits.
// - Watchdog expiry latches bit 31 until software clears it.
// - External interrupt and DAC-load flags latch on enabled configured line edges.
// - Conversion start and trigger flags latch on enabled configured line edges.
// - FIFO overrun flag latches when ADC acquires more than FIFO holds.
// - Almost-full flag latches when FIFO count reaches programmed threshold.
// - DMA timeout and DMA done flags latch on their events.
// - Writing one clears a latched status bit; zero leaves it.
// - Writing one to an enable bit enables that interrupt source.
// - Data register reads pins for input groups, written value for outputs.
// - Output group lines follow written data bits, one high, zero low.
// - Group direction bit set makes its eight lines outputs, clear inputs.
// - Enabled line 13 edge raises the external interrupt event.
// - Enabled line 12 edge loads all DACs and raises DAC-load event.
// - Enabled line 14 edge starts ADC and raises conversion-start event.
// - Enabled line 15 edge triggers timed conversions and raises trigger event.
// - Each secondary function has edge select, one rising, zero falling.
// - Watchdog counts base clock ticks, expires after programmed tick count.
// - Expiry resets the board fully except status output and watchdog flag.
// - Expiry drives the watchdog status output pin low.
`timescale 1ns/1ps
`include "iqdw_consts.svh"
module iqdw_ctrl
	import iqdw_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hostWrEn,
	input wire logic hostRdEn,
	input wire logic [7:0] hostAddr,
	input wire logic [31:0] hostWrData,
	output logic [31:0] hostRdData,
	output logic hostRdValid,
	output logic hostIrq,
	input wire logic [15:0] digitalLineIn,
	output logic [15:0] digitalLineOut,
	output logic [15:0] digitalLineOe,
	input wire logic adcTick,
	input wire logic fifoOverrunEvent,
	input wire logic fifoAlmostFullLevel,
	input wire logic dmaTimeoutEvent,
	input wire logic dmaDoneEvent,
	output logic dacLoadPulse,
	output logic convStartPulse,
	output logic convTriggerPulse,
	output logic boardResetPulse,
	output logic expiryStatusOutputN
);

	// Offset match; shared by the write and read decoders
	function automatic logic isOffset(input logic [7:0] addr, input logic [7:0] offset);
		isOffset = (addr == offset);
	endfunction : isOffset

	// Register state
	logic [8:0] irqEnable_reg;
	logic [8:0] irqEnable_next;
	logic [8:0] irqFlags_reg;
	logic [8:0] irqFlags_next;
	logic watchdogFiredFlag_reg;
	logic watchdogFiredFlag_next;
	logic [15:0] lineData_reg;
	logic [1:0] groupOutputSelect_reg;
	logic [7:0] secFuncCfg_reg;
	logic [31:0] wdgTimeout_reg;
	logic [31:0] wdgCount_reg;
	logic [31:0] wdgCount_next;
	iqdw_wdg_state_t wdgState_reg;
	iqdw_wdg_state_t wdgState_next;
	logic [31:0] rdData_reg;
	logic rdValid_reg;
	logic expiryStatusN_reg;

	// Decode and control wires
	logic hitIrq;
	logic hitLineData;
	logic hitLineCtrl;
	logic hitWdg;
	logic wrIrq;
	logic wrLineData;
	logic wrLineCtrl;
	logic wrWdg;
	logic [8:0] clearMask;
	logic [8:0] sourceEvent;
	logic [31:0] irqWord;
	logic [31:0] lineDataWord;
	logic [31:0] lineCtrlWord;
	logic [31:0] rdMux;
	logic [15:0] lineReadback;
	logic [15:0] groupOe;
	logic wdgExpire;
	logic localRst;
	logic extIrqPulse;
	logic dacLoadEvt;
	logic convStartEvt;
	logic convTriggerEvt;

	// Expiry acts as a power-on reset for everything but the fired flag and status pin
	assign wdgExpire = (wdgState_reg == IQDW_WDG_BARK);
	assign localRst = sys_rst | wdgExpire;

	// Address decode
	assign hitIrq = isOffset(hostAddr, `IQDW_OFF_IRQ);
	assign hitLineData = isOffset(hostAddr, `IQDW_OFF_DIGITAL_LINE_DATA);
	assign hitLineCtrl = isOffset(hostAddr, `IQDW_OFF_DIO_CTRL);
	assign hitWdg = isOffset(hostAddr, `IQDW_OFF_WDG);
	assign wrIrq = hostWrEn & hitIrq;
	assign wrLineData = hostWrEn & hitLineData;
	assign wrLineCtrl = hostWrEn & hitLineCtrl;
	assign wrWdg = hostWrEn & hitWdg;

	// Secondary function carrier; lane order is trigger, start, external, DAC load
	iqdw_sec_if secBus ();

	assign secBus.lineLevel = {digitalLineIn[`IQDW_PIN_DAC_LOAD_FLAG], digitalLineIn[`IQDW_PIN_EXT],
		digitalLineIn[`IQDW_PIN_START], digitalLineIn[`IQDW_PIN_TRIG]};
	// Control bits 22,20,18,16 are enables and 23,21,19,17 edge selects
	assign secBus.funcEnable = {secFuncCfg_reg[4], secFuncCfg_reg[6], secFuncCfg_reg[2],
		secFuncCfg_reg[0]};
	assign secBus.edgeRise = {secFuncCfg_reg[5], secFuncCfg_reg[7], secFuncCfg_reg[3],
		secFuncCfg_reg[1]};

	iqdw_edge_detect uEdge (
		.clk(clk),
		.rst(localRst),
		.sec(secBus.detect)
	);

	// Detector pulses, one cycle each
	assign convTriggerEvt = secBus.eventPulse[0];
	assign convStartEvt = secBus.eventPulse[1];
	assign extIrqPulse = secBus.eventPulse[2];
	assign dacLoadEvt = secBus.eventPulse[3];
	assign dacLoadPulse = dacLoadEvt;
	assign convStartPulse = convStartEvt;
	assign convTriggerPulse = convTriggerEvt;

	// Event vector in flag order; the second external source has no line and stays idle
	assign sourceEvent[`IQDW_SRC_TRIG] = convTriggerEvt;
	assign sourceEvent[`IQDW_SRC_START] = convStartEvt;
	assign sourceEvent[`IQDW_SRC_DMA_DONE_FLAG] = dmaDoneEvent;
	assign sourceEvent[`IQDW_SRC_DTO] = dmaTimeoutEvent;
	assign sourceEvent[`IQDW_SRC_FAF] = fifoAlmostFullLevel;
	assign sourceEvent[`IQDW_SRC_FOF] = fifoOverrunEvent;
	assign sourceEvent[`IQDW_SRC_DAC_LOAD_FLAG] = dacLoadEvt;
	assign sourceEvent[`IQDW_SRC_EXT0] = extIrqPulse;
	assign sourceEvent[`IQDW_SRC_EXT1] = 1'b0;

	// Write-one-to-clear; a new event in the same cycle wins over the clear
	assign clearMask = wrIrq ? hostWrData[`IQDW_IRQ_FLAG_MSB:`IQDW_IRQ_FLAG_LSB] : 9'h000;
	assign irqFlags_next = (irqFlags_reg & ~clearMask) | sourceEvent;
	// Enables store what is written, so writing back a read value keeps them
	assign irqEnable_next = wrIrq ? hostWrData[`IQDW_IRQ_EN_MSB:`IQDW_IRQ_EN_LSB] : irqEnable_reg;
	assign watchdogFiredFlag_next = wdgExpire |
		(watchdogFiredFlag_reg & ~(wrIrq & hostWrData[`IQDW_IRQ_WDG_BIT]));

	// Interrupt flag and enable storage, cleared by board reset
	always_ff @(posedge clk)
	begin
		if (localRst)
		begin
			irqFlags_reg <= `IQDW_RST_IRQ_FLAG;
			irqEnable_reg <= `IQDW_RST_IRQ_EN;
		end
		else
		begin
			irqFlags_reg <= irqFlags_next;
			irqEnable_reg <= irqEnable_next;
		end
	end

	// Fired flag and status pin survive the watchdog reset; the system reset or a one written to bit 31 clears them
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			watchdogFiredFlag_reg <= 1'b0;
			expiryStatusN_reg <= 1'b1;
		end
		else
		begin
			watchdogFiredFlag_reg <= watchdogFiredFlag_next;
			expiryStatusN_reg <= ~watchdogFiredFlag_next;
		end
	end

	assign expiryStatusOutputN = expiryStatusN_reg;
	assign boardResetPulse = wdgExpire;

	// Host interrupt: any enabled flag
	assign hostIrq = |(irqFlags_reg & irqEnable_reg);

	// Digital line data and control registers
	always_ff @(posedge clk)
	begin
		if (localRst)
		begin
			lineData_reg <= `IQDW_RST_DIGITAL_LINE_DATA;
			groupOutputSelect_reg <= `IQDW_RST_DIO_GRP;
			secFuncCfg_reg <= `IQDW_RST_DIO_SEC;
		end
		else
		begin
			if (wrLineData)
				lineData_reg <= hostWrData[15:0];
			if (wrLineCtrl)
			begin
				groupOutputSelect_reg <= hostWrData[`IQDW_DIO_GRP1_BIT:`IQDW_DIO_GRP0_BIT];
				secFuncCfg_reg <= hostWrData[`IQDW_DIO_SEC_MSB:`IQDW_DIO_SEC_LSB];
			end
		end
	end

	// Group direction; lines of an input group are left undriven
	genvar grp;
	generate
		for (grp = 0; grp < 2; grp = grp + 1)
		begin : gGroup
			assign groupOe[grp*8 +: 8] = {8{groupOutputSelect_reg[grp]}};
			assign lineReadback[grp*8 +: 8] = groupOutputSelect_reg[grp] ?
				lineData_reg[grp*8 +: 8] : digitalLineIn[grp*8 +: 8];
		end
	endgenerate

	assign digitalLineOe = groupOe;
	assign digitalLineOut = lineData_reg;

	// Watchdog sequencer; a zero timeout parks it in idle
	always_comb
	begin
		wdgState_next = wdgState_reg;
		wdgCount_next = wdgCount_reg;
		case (wdgState_reg)
			IQDW_WDG_IDLE:
			begin
				wdgCount_next = 32'h0000_0000;
				if (wdgTimeout_reg != 32'h0000_0000)
					wdgState_next = IQDW_WDG_COUNT;
			end
			IQDW_WDG_COUNT:
			begin
				if (wdgTimeout_reg == 32'h0000_0000)
				begin
					wdgState_next = IQDW_WDG_IDLE;
					wdgCount_next = 32'h0000_0000;
				end
				else if (adcTick)
				begin
					wdgCount_next = wdgCount_reg + 32'h0000_0001;
					if (wdgCount_next >= wdgTimeout_reg)
						wdgState_next = IQDW_WDG_BARK;
				end
			end
			IQDW_WDG_BARK:
			begin
				wdgState_next = IQDW_WDG_IDLE;
				wdgCount_next = 32'h0000_0000;
			end
			default:
			begin
				wdgState_next = IQDW_WDG_IDLE;
				wdgCount_next = 32'h0000_0000;
			end
		endcase
		// A timeout write restarts the count, which is how software services the watchdog
		if (wrWdg && (wdgState_reg != IQDW_WDG_BARK))
			wdgCount_next = 32'h0000_0000;
	end

	// Watchdog state, count and timeout; the bark itself clears the timeout to disabled
	always_ff @(posedge clk)
	begin
		if (localRst)
		begin
			wdgState_reg <= IQDW_WDG_IDLE;
			wdgCount_reg <= 32'h0000_0000;
			wdgTimeout_reg <= `IQDW_RST_WDG_TIMEOUT;
		end
		else
		begin
			wdgState_reg <= wdgState_next;
			wdgCount_reg <= wdgCount_next;
			if (wrWdg)
				wdgTimeout_reg <= hostWrData;
		end
	end

	// Read words; unused bits read as zero
	assign irqWord = {watchdogFiredFlag_reg, 6'h00, irqFlags_reg, 7'h00, irqEnable_reg};
	assign lineDataWord = {16'h0000, lineReadback};
	assign lineCtrlWord = {8'h00, secFuncCfg_reg, 14'h0000, groupOutputSelect_reg};
	assign rdMux = hitIrq ? irqWord :
		hitLineData ? lineDataWord :
		hitLineCtrl ? lineCtrlWord :
		hitWdg ? wdgTimeout_reg : `IQDW_RST_WORD;

	// Registered read answer, one cycle after the request
	always_ff @(posedge clk)
	begin
		if (localRst)
		begin
			rdData_reg <= `IQDW_RST_WORD;
			rdValid_reg <= 1'b0;
		end
		else
		begin
			rdValid_reg <= hostRdEn;
			if (hostRdEn)
				rdData_reg <= rdMux;
		end
	end

	assign hostRdData = rdData_reg;
	assign hostRdValid = rdValid_reg;

endmodule : iqdw_ctrl

// ==== logic/iqdw_edge_detect.sv ====
// Edge detector for the four digital line secondary functions
`timescale 1ns/1ps
`include "iqdw_consts.svh"
module iqdw_edge_detect
	import iqdw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	iqdw_sec_if.detect sec
);

	iqdw_sec_vec_t prevLevel_reg;
	iqdw_sec_vec_t pulse_reg;
	iqdw_sec_vec_t hitEdge;

	// Per lane edge select: one picks rising, zero picks falling
	genvar lane;
	generate
		for (lane = 0; lane < `IQDW_SEC_COUNT; lane = lane + 1)
		begin : gLane
			assign hitEdge[lane] = sec.funcEnable[lane] & (sec.edgeRise[lane] ?
				(sec.lineLevel[lane] & ~prevLevel_reg[lane]) :
				(~sec.lineLevel[lane] & prevLevel_reg[lane]));
		end
	endgenerate

	// Previous level tracks the pin even while disabled, so enabling never fakes an edge
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prevLevel_reg <= 4'h0;
			pulse_reg <= 4'h0;
		end
		else
		begin
			prevLevel_reg <= sec.lineLevel;
			pulse_reg <= hitEdge;
		end
	end

	assign sec.eventPulse = pulse_reg;

endmodule : iqdw_edge_detect

// ==== logic/iqdw_pkg.sv ====
// Types shared by the interrupt, digital line and watchdog control logic
package iqdw_pkg;

	// Watchdog sequencer states, one-hot
	typedef enum logic [2:0] {
		IQDW_WDG_IDLE = 3'h1,
		IQDW_WDG_COUNT = 3'h2,
		IQDW_WDG_BARK = 3'h4
	} iqdw_wdg_state_t;

	// Secondary function lanes
	typedef logic [3:0] iqdw_sec_vec_t;

endpackage : iqdw_pkg

// ==== logic/iqdw_sec_if.sv ====
// Carrier between the control core and the secondary function edge detector
`timescale 1ns/1ps
interface iqdw_sec_if;
	import iqdw_pkg::*;
	iqdw_sec_vec_t lineLevel;
	iqdw_sec_vec_t funcEnable;
	iqdw_sec_vec_t edgeRise;
	iqdw_sec_vec_t eventPulse;

	modport core (output lineLevel, output funcEnable, output edgeRise, input eventPulse);
	modport detect (input lineLevel, input funcEnable, input edgeRise, output eventPulse);
endinterface : iqdw_sec_if

// ==== verif/iqdw_ctrl_props.sv ====
// Checker on the control core ports
`timescale 1ns/1ps
`include "iqdw_consts.svh"
module iqdw_ctrl_props
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hostWrEn,
	input wire logic hostRdEn,
	input wire logic [7:0] hostAddr,
	input wire logic [31:0] hostWrData,
	input wire logic [31:0] hostRdData,
	input wire logic hostRdValid,
	input wire logic hostIrq,
	input wire logic [15:0] digitalLineOut,
	input wire logic [15:0] digitalLineOe,
	input wire logic dacLoadPulse,
	input wire logic boardResetPulse,
	input wire logic expiryStatusOutputN
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Strobes in the bark cycle are dropped, so they are left out
	wire rdOk = hostRdEn && !boardResetPulse;
	wire wrOk = hostWrEn && !boardResetPulse;
	wire isCtrl = hostAddr == `IQDW_OFF_DIO_CTRL;
	wire isData = hostAddr == `IQDW_OFF_DIGITAL_LINE_DATA;
	wire mapped = hostAddr inside {`IQDW_OFF_IRQ, `IQDW_OFF_DIGITAL_LINE_DATA, `IQDW_OFF_DIO_CTRL, `IQDW_OFF_WDG};

	// Bus answers
	a_read_answer: assert property (rdOk |=> hostRdValid) else $error("read lost");
	a_valid_cause: assert property (hostRdValid |-> $past(hostRdEn)) else $error("stray valid");
	a_unmapped_zero: assert property (rdOk && !mapped |=> hostRdData == 32'h0) else $error("unmapped");
	// Line direction and data
	a_group_dir: assert property (wrOk && isCtrl |=>
		{digitalLineOe[8], digitalLineOe[0]} == $past(hostWrData[1:0])) else $error("dir");
	a_group_whole: assert property (digitalLineOe[7:0] inside {8'h00, 8'hFF} &&
		digitalLineOe[15:8] inside {8'h00, 8'hFF}) else $error("split group");
	a_out_data: assert property (wrOk && isData |=> digitalLineOut == $past(hostWrData[15:0])) else $error("out");
	// Watchdog bark and DAC load pulse
	a_bark_single: assert property (boardResetPulse |=> !boardResetPulse) else $error("long bark");
	a_bark_clear: assert property (boardResetPulse |=>
		digitalLineOe == 16'h0000 && digitalLineOut == 16'h0000 && !hostIrq) else $error("no reset");
	a_expiry_low: assert property (boardResetPulse |=> !expiryStatusOutputN) else $error("pin high");
	a_expiry_cause: assert property ($fell(expiryStatusOutputN) |-> $past(boardResetPulse)) else $error("pin");
	a_load_single: assert property (dacLoadPulse |=> !dacLoadPulse) else $error("load");

	c_bark: cover property (boardResetPulse);
	c_irq: cover property ($rose(hostIrq));
	c_load: cover property (dacLoadPulse);
endmodule : iqdw_ctrl_props

bind iqdw_ctrl iqdw_ctrl_props u_props (.clk(clk), .sys_rst(sys_rst), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn),
	.hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
	.hostIrq(hostIrq), .digitalLineOut(digitalLineOut), .digitalLineOe(digitalLineOe),
	.dacLoadPulse(dacLoadPulse), .boardResetPulse(boardResetPulse), .expiryStatusOutputN(expiryStatusOutputN));

// ==== verif/iqdw_ctrl_test.sv ====
// Self-checking bench for the control core
`timescale 1ns/1ps
`include "iqdw_consts.svh"
module iqdw_ctrl_test;
	import iqdw_pkg::*;
	logic clk, sys_rst, hostWrEn, hostRdEn, adcTick, seen;
	logic hostRdValid, hostIrq, dacLoadPulse, convStartPulse, convTriggerPulse, boardResetPulse, expiryStatusOutputN;
	logic [3:0] evt;
	logic [7:0] hostAddr;
	logic [31:0] hostWrData, hostRdData, rdv;
	logic [15:0] digitalLineIn, digitalLineOut, digitalLineOe, extLevel, seed;
	int mismatches, n_checks, nt;
	wire [3:0] secPulse = {dacLoadPulse, hostIrq, convStartPulse, convTriggerPulse};

	iqdw_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn), .hostAddr(hostAddr),
		.hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid), .hostIrq(hostIrq),
		.digitalLineIn(digitalLineIn), .digitalLineOut(digitalLineOut), .digitalLineOe(digitalLineOe),
		.adcTick(adcTick), .fifoOverrunEvent(evt[0]), .fifoAlmostFullLevel(evt[1]), .dmaTimeoutEvent(evt[2]),
		.dmaDoneEvent(evt[3]), .dacLoadPulse(dacLoadPulse), .convStartPulse(convStartPulse),
		.convTriggerPulse(convTriggerPulse), .boardResetPulse(boardResetPulse),
		.expiryStatusOutputN(expiryStatusOutputN));
	iqdw_pins u_pins (.lineOut(digitalLineOut), .lineOe(digitalLineOe), .extLevel(extLevel), .lineIn(digitalLineIn));

	// Free-running clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Expected values
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	function automatic logic [15:0] dioExp(input logic [1:0] g, input logic [15:0] d, input logic [15:0] e);
		logic [15:0] m;
		m = {{8{g[1]}}, {8{g[0]}}};
		return (d & m) | (e & ~m);
	endfunction : dioExp
	function automatic int flagBit(input int i);
		return (i < 2) ? 16 + i : 25 - i;
	endfunction : flagBit
	// Control enable position per lane; external sits above DAC load, edge select one bit higher
	function automatic int ctrlBit(input int i);
		return (i < 2) ? 16 + 2 * i : 26 - 2 * i;
	endfunction : ctrlBit

	// Bus and compare tasks, strobes move on the falling edge
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		hostAddr = a;
		hostWrData = d;
		hostWrEn = 1'b1;
		@(negedge clk);
		hostWrEn = 1'b0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
		@(negedge clk);
		hostAddr = a;
		hostRdEn = 1'b1;
		@(negedge clk);
		hostRdEn = 1'b0;
		chk(hostRdValid, 32'h1, "valid");
		chk(hostRdData, e, m);
	endtask : rc
	task automatic conclude;
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	// Main sequence
	initial
	begin
		sys_rst = 1'b1;
		{hostWrEn, hostRdEn, adcTick, evt} = 7'h00;
		hostAddr = 8'h00;
		hostWrData = 32'h0;
		extLevel = 16'h0;
		seed = 16'h0028;
		mismatches = 0;
		n_checks = 0;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		rc(`IQDW_OFF_IRQ, 32'h0, "irq rst");
		rc(`IQDW_OFF_DIO_CTRL, 32'h0, "ctrl rst");
		rc(`IQDW_OFF_WDG, 32'h0, "wdg rst");
		chk(expiryStatusOutputN, 32'h1, "pin rst");
		// Both groups in every direction with random data
		for (int g = 0; g < 4; g++)
		begin
			seed = nx(seed);
			rdv = {16'h0, seed};
			wr(`IQDW_OFF_DIO_CTRL, 32'(g));
			wr(`IQDW_OFF_DIGITAL_LINE_DATA, rdv);
			seed = nx(seed);
			extLevel = seed;
			repeat (3) @(negedge clk);
			chk(digitalLineOe, {16'h0, dioExp(g[1:0], 16'hFFFF, 16'h0)}, "oe");
			chk(digitalLineOut, {16'h0, rdv[15:0]}, "out");
			rc(`IQDW_OFF_DIGITAL_LINE_DATA, {16'h0, dioExp(g[1:0], rdv[15:0], seed)}, "dio");
		end
		wr(8'h50, 32'hFFFF_FFFF);
		rc(8'h50, 32'h0, "unmapped");
		rc(`IQDW_OFF_DIGITAL_LINE_DATA, rdv, "kept");
		// Board events latch regardless of enable, enable gates the request
		for (int k = 0; k < 4; k++)
		begin
			@(negedge clk);
			evt[k] = 1'b1;
			@(negedge clk);
			evt[k] = 1'b0;
			chk(hostIrq, 32'h0, "masked");
			rc(`IQDW_OFF_IRQ, 32'h1 << (21 - k), "event");
			wr(`IQDW_OFF_IRQ, 32'h1 << (5 - k));
			chk(hostIrq, 32'h1, "irq on");
			// Enables are plain storage, so the clear write carries the enable back
			wr(`IQDW_OFF_IRQ, 32'h1 << (21 - k) | 32'h1 << (5 - k));
			rc(`IQDW_OFF_IRQ, 32'h1 << (5 - k), "clear");
			wr(`IQDW_OFF_IRQ, 32'h0);
		end
		// Lines back to inputs first, else the switch from driven data fakes an edge
		wr(`IQDW_OFF_DIO_CTRL, 32'h0);
		// Secondary functions, wrong edge first then the selected one
		for (int i = 0; i < 4; i++)
			for (int e = 0; e < 2; e++)
			begin
				extLevel[15 - i] = e[0];
				wr(`IQDW_OFF_DIO_CTRL, 32'h1 << ctrlBit(i) | 32'(e) << (ctrlBit(i) + 1));
				wr(`IQDW_OFF_IRQ, 32'h1 << (flagBit(i) - 16));
				extLevel[15 - i] = ~e[0];
				repeat (5) @(negedge clk);
				chk(hostIrq, 32'h0, "wrong edge");
				extLevel[15 - i] = e[0];
				seen = 1'b0;
				repeat (6)
				begin
					@(negedge clk);
					seen = seen | secPulse[i];
				end
				chk(seen, 32'h1, "edge");
				if (!seen)
					conclude();
				rc(`IQDW_OFF_IRQ, 32'h1 << flagBit(i) | 32'h1 << (flagBit(i) - 16), "sec");
				wr(`IQDW_OFF_IRQ, 32'h1 << flagBit(i));
				chk(hostIrq, 32'h0, "irq off");
				wr(`IQDW_OFF_DIO_CTRL, 32'h0);
			end
		// Watchdog expiry after three ticks
		wr(`IQDW_OFF_DIO_CTRL, 32'h3);
		wr(`IQDW_OFF_IRQ, 32'h1FF);
		wr(`IQDW_OFF_WDG, 32'h3);
		seen = 1'b0;
		nt = 0;
		for (int t = 0; t < 40 && !seen; t++)
		begin
			@(negedge clk);
			seen = boardResetPulse;
			adcTick = t[0] & !seen;
			nt += adcTick;
		end
		adcTick = 1'b0;
		chk(seen, 32'h1, "bark");
		chk(nt, 32'h3, "ticks");
		if (!seen)
			conclude();
		@(negedge clk);
		chk(expiryStatusOutputN, 32'h0, "pin low");
		rc(`IQDW_OFF_IRQ, 32'h8000_0000, "wdg flag");
		rc(`IQDW_OFF_DIO_CTRL, 32'h0, "ctrl bark");
		rc(`IQDW_OFF_WDG, 32'h0, "wdg bark");
		wr(`IQDW_OFF_IRQ, 32'h8000_0000);
		rc(`IQDW_OFF_IRQ, 32'h0, "wdg clr");
		// Zero timeout never barks
		seen = 1'b0;
		repeat (40)
		begin
			@(negedge clk);
			adcTick = ~adcTick;
			seen = seen | boardResetPulse;
		end
		chk(seen, 32'h0, "idle wdg");
		conclude();
	end
endmodule : iqdw_ctrl_test

// ==== verif/iqdw_pins.sv ====
// Board-side model of the sixteen digital lines
`timescale 1ns/1ps
module iqdw_pins
(
	input wire logic [15:0] lineOut,
	input wire logic [15:0] lineOe,
	input wire logic [15:0] extLevel,
	output logic [15:0] lineIn
);
	// Driven lines read back the core, others the outside level
	assign lineIn = (lineOut & lineOe) | (extLevel & ~lineOe);
endmodule : iqdw_pins
